// ### ccpm_regs.vh
// Register offsets, field positions and reset values of the capture/compare/PWM mode control
`ifndef CCPM_REGS_VH
`define CCPM_REGS_VH
`define CCPM_IDX_UNIT_ONE_CTRL 8'h17
`define CCPM_IDX_UNIT_TWO_CTRL 8'h1D
`define CCPM_ADDR_UNIT_ONE_CTRL 10'h05C
`define CCPM_ADDR_UNIT_TWO_CTRL 10'h074
`define CCPM_ADDR_ONE_COMPARE 10'h100
`define CCPM_ADDR_TWO_COMPARE 10'h104
`define CCPM_ADDR_ONE_CAPTURE 10'h108
`define CCPM_ADDR_TWO_CAPTURE 10'h10C
`define CCPM_ADDR_IRQ_STATUS 10'h110
`define CCPM_ADDR_IRQ_MASK 10'h114
`define CCPM_ADDR_STATE 10'h118
`define CCPM_CTRL_WMASK 8'h3F
`define CCPM_CTRL_RESET 8'h00
`define CCPM_MODE_OFF 4'h0
`define CCPM_MODE_CAP_FALL 4'h4
`define CCPM_MODE_CAP_RISE 4'h5
`define CCPM_MODE_CAP_RISE4 4'h6
`define CCPM_MODE_CAP_RISE16 4'h7
`define CCPM_MODE_CMP_SET 4'h8
`define CCPM_MODE_CMP_CLR 4'h9
`define CCPM_MODE_CMP_SWI 4'hA
`define CCPM_MODE_CMP_TRIG 4'hB
`define CCPM_PRESCALE_4 4'h3
`define CCPM_PRESCALE_16 4'hF
`endif

// ### ccpm_mode_control.v
// Two capture/compare/PWM units with AHB-Lite register access
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ccpm_regs.vh"
module ccpm_mode_control (
    input wire clk_sys,
    input wire srst,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hsel,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire unit_one_pin_in,
    input wire unit_two_pin_in,
    input wire [15:0] timer_one_count,
    input wire converter_enabled,
    output reg unit_one_out,
    output reg unit_two_out,
    output reg [9:0] unit_one_duty,
    output reg [9:0] unit_two_duty,
    output reg unit_one_pwm_mode,
    output reg unit_two_pwm_mode,
    output reg timer_one_reset,
    output reg conversion_start,
    output reg irq
);

    // Capture-event decision for one unit given edges and prescale count
    function cap_event;
        input [3:0] mode;
        input rise;
        input fall;
        input [3:0] cnt;
        begin
            case (mode)
                `CCPM_MODE_CAP_FALL: cap_event = fall;
                `CCPM_MODE_CAP_RISE: cap_event = rise;
                `CCPM_MODE_CAP_RISE4: cap_event = rise && ((cnt & `CCPM_PRESCALE_4) == `CCPM_PRESCALE_4);
                `CCPM_MODE_CAP_RISE16: cap_event = rise && cnt == `CCPM_PRESCALE_16;
                default: cap_event = 1'b0;
            endcase
        end
    endfunction

    // Control register as seen on the bus; unimplemented top bits read zero
    function [31:0] ctrl_word;
        input [7:0] ctrl;
        begin
            ctrl_word = {24'h000000, 2'b00, ctrl[5:0]};
        end
    endfunction

    function is_capture;
        input [3:0] mode;
        begin
            is_capture = (mode[3:2] == 2'b01);
        end
    endfunction

    function is_compare;
        input [3:0] mode;
        begin
            is_compare = (mode[3:2] == 2'b10);
        end
    endfunction

    function is_pwm;
        input [3:0] mode;
        begin
            is_pwm = (mode[3:2] == 2'b11);
        end
    endfunction

    // Special event trigger: compare match while in mode 1011
    function is_trigger;
        input [3:0] mode;
        input hit;
        begin
            is_trigger = hit && (mode == `CCPM_MODE_CMP_TRIG);
        end
    endfunction

    // Next level of the compare output latch
    function out_next;
        input [3:0] mode;
        input hit;
        input cur;
        begin
            case (mode)
                `CCPM_MODE_OFF: out_next = 1'b0;
                `CCPM_MODE_CMP_SET: out_next = hit ? 1'b1 : cur;
                `CCPM_MODE_CMP_CLR: out_next = hit ? 1'b0 : cur;
                default: out_next = cur;
            endcase
        end
    endfunction

    // Prescaler counts rising edges only while capturing, else it is held clear
    function [3:0] pre_next;
        input [3:0] mode;
        input rise;
        input [3:0] cnt;
        begin
            if (!is_capture(mode))
                pre_next = 4'h0;
            else if (rise)
                pre_next = cnt + 4'h1;
            else
                pre_next = cnt;
        end
    endfunction

    reg [7:0] ctrl1_q, ctrl2_q;
    reg [15:0] cmp1_q, cmp2_q, cap1_q, cap2_q;
    reg [1:0] stat_q, mask_q;
    reg [3:0] pre1_q, pre2_q;
    reg s1a_q, s1b_q, s1c_q, s2a_q, s2b_q, s2c_q;
    reg aph_q, awr_q;
    reg [9:0] aad_q;

    wire [3:0] m1 = ctrl1_q[3:0];
    wire [3:0] m2 = ctrl2_q[3:0];
    // Pin edges seen on the synchronised copies
    wire r1 = s1b_q & ~s1c_q;
    wire f1 = ~s1b_q & s1c_q;
    wire r2 = s2b_q & ~s2c_q;
    wire f2 = ~s2b_q & s2c_q;
    wire cm1 = is_compare(m1);
    wire cm2 = is_compare(m2);
    wire hit1 = cm1 && (cmp1_q == timer_one_count);
    wire hit2 = cm2 && (cmp2_q == timer_one_count);
    wire ce1 = is_capture(m1) && cap_event(m1, r1, f1, pre1_q);
    wire ce2 = is_capture(m2) && cap_event(m2, r2, f2, pre2_q);
    wire tr1 = is_trigger(m1, hit1);
    wire tr2 = is_trigger(m2, hit2);
    wire wr = aph_q && awr_q;
    wire [7:0] wb = hwdata[7:0];
    wire [1:0] ev = {ce2 | hit2, ce1 | hit1};
    wire st_clr = wr && (aad_q == `CCPM_ADDR_IRQ_STATUS);
    // Flag set wins over a same-cycle write-one clear
    wire [1:0] stat_d = (st_clr ? (stat_q & ~hwdata[1:0]) : stat_q) | ev;

    // Two-stage synchronisers; the third stage only feeds edge detection
    always @(posedge clk_sys) begin
        s1a_q <= unit_one_pin_in;
        s1b_q <= s1a_q;
        s1c_q <= s1b_q;
        s2a_q <= unit_two_pin_in;
        s2b_q <= s2a_q;
        s2c_q <= s2b_q;
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            aph_q <= 1'b0;
            awr_q <= 1'b0;
            aad_q <= 10'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                aph_q <= hsel && htrans[1];
                awr_q <= hwrite;
                aad_q <= haddr[9:0];
                hrdata <= 32'h00000000;
                if (hsel && htrans[1] && !hwrite) begin
                    case (haddr[9:0])
                        `CCPM_ADDR_UNIT_ONE_CTRL: hrdata <= ctrl_word(ctrl1_q);
                        `CCPM_ADDR_UNIT_TWO_CTRL: hrdata <= ctrl_word(ctrl2_q);
                        `CCPM_ADDR_ONE_COMPARE: hrdata <= {16'h0000, cmp1_q};
                        `CCPM_ADDR_TWO_COMPARE: hrdata <= {16'h0000, cmp2_q};
                        `CCPM_ADDR_ONE_CAPTURE: hrdata <= {16'h0000, cap1_q};
                        `CCPM_ADDR_TWO_CAPTURE: hrdata <= {16'h0000, cap2_q};
                        `CCPM_ADDR_IRQ_STATUS: hrdata <= {30'h00000000, stat_q};
                        `CCPM_ADDR_IRQ_MASK: hrdata <= {30'h00000000, mask_q};
                        `CCPM_ADDR_STATE: hrdata <= {22'h000000, unit_two_out, unit_one_out,
                            pre2_q, pre1_q};
                        default: hrdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            ctrl1_q <= `CCPM_CTRL_RESET;
            ctrl2_q <= `CCPM_CTRL_RESET;
            cmp1_q <= 16'h0000;
            cmp2_q <= 16'h0000;
            mask_q <= 2'b00;
        end else if (wr) begin
            case (aad_q)
                `CCPM_ADDR_UNIT_ONE_CTRL: ctrl1_q <= wb & `CCPM_CTRL_WMASK;
                `CCPM_ADDR_UNIT_TWO_CTRL: ctrl2_q <= wb & `CCPM_CTRL_WMASK;
                `CCPM_ADDR_ONE_COMPARE: cmp1_q <= hwdata[15:0];
                `CCPM_ADDR_TWO_COMPARE: cmp2_q <= hwdata[15:0];
                `CCPM_ADDR_IRQ_MASK: mask_q <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            stat_q <= 2'b00;
            irq <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end

    // Prescalers; cleared whenever the unit is not capturing
    always @(posedge clk_sys) begin
        if (srst) begin
            pre1_q <= 4'h0;
        end else begin
            pre1_q <= pre_next(m1, r1, pre1_q);
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            pre2_q <= 4'h0;
        end else begin
            pre2_q <= pre_next(m2, r2, pre2_q);
        end
    end

    // A new capture overwrites one that was not yet read
    always @(posedge clk_sys) begin
        if (srst) begin
            cap1_q <= 16'h0000;
            cap2_q <= 16'h0000;
        end else begin
            if (ce1)
                cap1_q <= timer_one_count;
            if (ce2)
                cap2_q <= timer_one_count;
        end
    end

    // Compare output latches
    always @(posedge clk_sys) begin
        if (srst) begin
            unit_one_out <= 1'b0;
        end else begin
            unit_one_out <= out_next(m1, hit1, unit_one_out);
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            unit_two_out <= 1'b0;
        end else begin
            unit_two_out <= out_next(m2, hit2, unit_two_out);
        end
    end

    // Modes 1010 and 1011 leave the output latch alone
    always @(posedge clk_sys) begin
        if (srst) begin
            timer_one_reset <= 1'b0;
            conversion_start <= 1'b0;
            unit_one_pwm_mode <= 1'b0;
            unit_two_pwm_mode <= 1'b0;
            unit_one_duty <= 10'h000;
            unit_two_duty <= 10'h000;
        end else begin
            timer_one_reset <= tr1 || tr2;
            conversion_start <= tr2 && converter_enabled;
            unit_one_pwm_mode <= is_pwm(m1);
            unit_two_pwm_mode <= is_pwm(m2);
            unit_one_duty <= {cmp1_q[7:0], ctrl1_q[5:4]};
            unit_two_duty <= {cmp2_q[7:0], ctrl2_q[5:4]};
        end
    end

endmodule
`default_nettype wire

// ### ccpm_sva.sv
// Port-level assertions for the mode control block
`timescale 1ns/100ps
`default_nettype none
module ccpm_sva (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hsel,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic converter_enabled,
    input wire logic unit_one_pwm_mode,
    input wire logic unit_two_pwm_mode,
    input wire logic timer_one_reset,
    input wire logic conversion_start,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic rd = hsel && htrans[1] && !hwrite;
    wire logic pwm2 = unit_one_pwm_mode && unit_two_pwm_mode;
    bus_okay_a: assert property (!hresp && hreadyout)
        else $error("bus answer not OKAY");
    ctrl_read_a: assert property (rd && haddr[9:0] inside {10'h05C, 10'h074}
        |=> hrdata[31:6] == '0) else $error("control read shows upper bits");
    unmapped_read_a: assert property (rd && haddr[9:0] > 10'h118 |=> hrdata == '0)
        else $error("unmapped read not zero");
    reset_clear_a: assert property ($fell(srst) |-> !(irq || timer_one_reset))
        else $error("outputs not clear after reset");
    conv_trig_a: assert property (conversion_start |-> timer_one_reset)
        else $error("conversion start without timer reset");
    conv_enable_a: assert property (conversion_start |-> $past(converter_enabled))
        else $error("conversion start while converter off");
    pwm_notrig_a: assert property (pwm2 [*2] |-> !timer_one_reset)
        else $error("timer reset with both units in PWM");
    pwm_noconv_a: assert property (unit_two_pwm_mode [*2] |-> !conversion_start)
        else $error("conversion start in PWM");
    cover property (conversion_start);
    cover property ($rose(irq));
    cover property (pwm2);
endmodule
`default_nettype wire

// ### ccpm_pin_model.sv
// Capture pin model: whole high-low-high pulses
`timescale 1ns/100ps
`default_nettype none
module ccpm_pin_model (
    input wire logic clk_sys,
    input wire logic [4:0] edges,
    input wire logic go,
    output var logic pin,
    output wire logic busy
);
    logic [5:0] left_q = '0;
    logic [2:0] div_q = '0;
    initial pin = 1'h1;
    // Idle high; each level lasts eight clocks so the synchroniser sees it
    always @(posedge clk_sys) begin
        if (go) begin
            left_q <= {edges, 1'h0};
        end else if (left_q != '0) begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
                pin <= ~pin;
                left_q <= left_q - 6'h1;
            end
        end
    end
    assign busy = go || left_q != '0;
endmodule
`default_nettype wire

// ### ccpm_tb.sv
// Self-checking testbench for the mode control block
`timescale 1ns/100ps
`default_nettype none
`include "ccpm_regs.vh"
module testbench;
    localparam logic [9:0] CT1 = `CCPM_ADDR_UNIT_ONE_CTRL, CT2 = `CCPM_ADDR_UNIT_TWO_CTRL;
    localparam logic [9:0] IST = `CCPM_ADDR_IRQ_STATUS, IMK = `CCPM_ADDR_IRQ_MASK;
    logic clk_sys = 0, srst = 1, hwrite = 0, hsel = 0, converter_enabled = 0, go = 0;
    logic hreadyout, hresp, unit_one_pin_in, unit_one_out, unit_one_pwm_mode, unit_two_pwm_mode;
    logic timer_one_reset, conversion_start, irq, busy;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [15:0] timer_one_count = '0;
    logic unit_two_out;
    logic [9:0] unit_one_duty, unit_two_duty;
    logic [4:0] edges = '0;
    logic [1:0] htrans = '0;
    logic [3:0] cm [5] = '{4'h8, 4'hA, 4'h9, 4'h8, 4'h0};
    logic [4:0] ce = 5'h0B;
    int err_count = 0, compares = 0, cycles = 0, i;
    always #5 clk_sys = ~clk_sys;
    ccpm_pin_model pm (.clk_sys, .edges, .go, .pin(unit_one_pin_in), .busy);
    ccpm_mode_control dut (.clk_sys(clk_sys), .srst(srst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .unit_one_pin_in(unit_one_pin_in), .unit_two_pin_in(unit_one_pin_in),
        .timer_one_count(timer_one_count), .converter_enabled(converter_enabled),
        .unit_one_out(unit_one_out), .unit_two_out(unit_two_out),
        .unit_one_duty(unit_one_duty), .unit_two_duty(unit_two_duty),
        .unit_one_pwm_mode(unit_one_pwm_mode), .unit_two_pwm_mode(unit_two_pwm_mode),
        .timer_one_reset(timer_one_reset), .conversion_start(conversion_start), .irq(irq));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic ahb(input logic w, input logic [9:0] a, input logic [31:0] d);
        haddr <= {22'h0, a};
        hwrite <= w;
        hsel <= 1'h1;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task automatic rc(input string n, input logic [9:0] a, input logic [31:0] e);
        ahb(1'h0, a, '0);
        chk(n, e, r);
    endtask
    task automatic pulse(input logic [4:0] n);
        edges <= n;
        go <= 1'h1;
        @(posedge clk_sys);
        go <= 1'h0;
        do @(posedge clk_sys); while (busy);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic finish_test;
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'h0;
        rc("ctrl two", CT2, '0);
        ahb(1'h1, CT1, 32'hFF);
        rc("ctrl one", CT1, 32'h3F);
        ahb(1'h1, `CCPM_ADDR_ONE_COMPARE, 32'hAB);
        ahb(1'h1, CT2, 32'h2F);
        ahb(1'h1, `CCPM_ADDR_TWO_COMPARE, 32'hCD);
        repeat (3) @(posedge clk_sys);
        chk("duty", {8'hAB, 2'h3}, unit_one_duty);
        chk("duty two", {8'hCD, 2'h2}, unit_two_duty);
        for (i = 0; i < 16; i++) begin
            ahb(1'h1, CT1, i);
            ahb(1'h1, CT2, i);
            repeat (2) @(posedge clk_sys);
            chk("pwm one", i >= 12, unit_one_pwm_mode);
            chk("pwm two", i >= 12, unit_two_pwm_mode);
        end
        for (i = 4; i < 8; i++) begin
            ahb(1'h1, CT1, '0);
            ahb(1'h1, CT2, '0);
            timer_one_count <= 16'h1000 + 16'(i);
            ahb(1'h1, CT1, i);
            ahb(1'h1, CT2, i);
            ahb(1'h1, IST, 32'h3);
            pulse(i == 6 ? 5'h3 : i == 7 ? 5'hF : 5'h0);
            rc("early flag", IST, '0);
            pulse(5'h1);
            rc("flag", IST, 32'h3);
            rc("capture one", `CCPM_ADDR_ONE_CAPTURE, 32'h1000 + i);
            rc("capture two", `CCPM_ADDR_TWO_CAPTURE, 32'h1000 + i);
        end
        ahb(1'h1, `CCPM_ADDR_ONE_COMPARE, 32'h5555);
        ahb(1'h1, `CCPM_ADDR_TWO_COMPARE, 32'h5555);
        timer_one_count <= 16'h5555;
        for (i = 0; i < 5; i++) begin
            ahb(1'h1, CT1, cm[i]);
            ahb(1'h1, CT2, cm[i]);
            repeat (3) @(posedge clk_sys);
            chk("compare out", ce[i], unit_one_out);
            chk("compare out two", ce[i], unit_two_out);
        end
        converter_enabled <= 1'h1;
        ahb(1'h1, CT2, 32'h8);
        ahb(1'h1, CT2, 32'hB);
        repeat (3) @(posedge clk_sys);
        chk("trigger", 1'h1, timer_one_reset);
        chk("conversion", 1'h1, conversion_start);
        chk("trigger pin", 1'h1, unit_two_out);
        converter_enabled <= 1'h0;
        ahb(1'h1, IMK, 32'h1);
        ahb(1'h1, IST, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("conversion off", 1'h0, conversion_start);
        chk("irq masked", 1'h0, irq);
        ahb(1'h1, IMK, 32'h2);
        repeat (2) @(posedge clk_sys);
        chk("irq", 1'h1, irq);
        timer_one_count <= 16'h0;
        ahb(1'h1, IST, 32'h3);
        repeat (2) @(posedge clk_sys);
        chk("irq clear", 1'h0, irq);
        rc("unmapped", 10'h3F0, '0);
        finish_test;
    end
endmodule
bind ccpm_mode_control ccpm_sva u_sva (.clk_sys(clk_sys), .srst(srst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .converter_enabled(converter_enabled),
    .unit_one_pwm_mode(unit_one_pwm_mode), .unit_two_pwm_mode(unit_two_pwm_mode),
    .timer_one_reset(timer_one_reset), .conversion_start(conversion_start), .irq(irq));
`default_nettype wire
